// [verilog/tcpcpr_seq.sv]
// Overview of operation
// - Supply becoming valid on VDD or VBUS runs reset: defaults load, fuses read.
// - Writing one to the soft reset bit repeats the full power-on reset.
// - Unpowered, both CC lines show open: no pull-up, no pull-down.
// - With VDD present, CC pull-ups apply; role control starts at 0x05.
// - Strap pin is sampled at power-up, then driven as push-pull output.
// - Slave address comes from bus pin pairing and latched strap level.
// - Address is 10100, bit2 second pairing, bit1 strap, bit0 read/write.
// - Interrupt is active-low open-drain, pulled low to call the host.
// - Interrupt asserts after power-up and soft reset for power and init events.
// - Host clears event by writing one; zero leaves it; pin released when none.
// - High-voltage source switch output is high for on, low for off.
// - VBUS source switch output is high for on, low for off.
module tcpcpr_seq
   import tcpcpr_pkg::*;
#(
   parameter int FUSES = FUSE_WORDS,
   parameter int HOLD  = POR_HOLD_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire tcpcpr_pkg::tcpcpr_supply_t supply_pin,
   input  wire logic                   strap_pin_in,
   input  wire logic                   bus_pair2,
   input  wire logic                   soft_reset_bit_wr,
   input  wire tcpcpr_pkg::tcpcpr_clr_t clr_wr,
   input  wire tcpcpr_pkg::tcpcpr_ctrl_t ctrl_in,
   input  wire logic [7:0]             role_wr_data,
   input  wire logic                   role_wr,
   input  wire logic [7:0]             fuse_rd_data,
   output logic [$clog2(FUSES)-1:0]    fuse_rd_idx,
   output logic [7:0]                  fuse_trim [FUSES],
   output logic                        regs_default,
   output logic                        soft_reset_bit,
   output logic [7:0]                  cc_role_control,
   output logic                        cc_terms_enable,
   output logic [7:0]                  slave_addr,
   output logic                        orient_addr_strap_pin_out,
   output logic                        orient_addr_strap_pin_oe,
   output logic                        int_n_out,
   output logic                        int_n_oe,
   output logic                        port_pwr_event,
   output logic                        init_event,
   output logic                        hv_source_switch_out,
   output logic                        vbus_source_switch_out,
   output logic                        ready
);
   import tcpcpr_pkg::*;

   // The 8-bit phase counter bounds both the fuse count and the load hold
   if (FUSES < 2 || FUSES > 256 || HOLD < 1 || HOLD > 256) begin : g_bad_param
      $error("tcpcpr_seq: bad parameters");
   end

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   tcpcpr_supply_t sup_s1_ff, sup_s2_ff;
   logic           strap_s1_ff, strap_s2_ff, pair_s1_ff, pair_s2_ff;
   logic           pwr_ok, pwr_ok_d_ff;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sup_s1_ff   <= '0;
         sup_s2_ff   <= '0;
         strap_s1_ff <= 1'b0;
         strap_s2_ff <= 1'b0;
         pair_s1_ff  <= 1'b0;
         pair_s2_ff  <= 1'b0;
      end else begin
         sup_s1_ff   <= supply_pin;
         sup_s2_ff   <= sup_s1_ff;
         strap_s1_ff <= strap_pin_in;
         strap_s2_ff <= strap_s1_ff;
         pair_s1_ff  <= bus_pair2;
         pair_s2_ff  <= pair_s1_ff;
      end
   end

   assign pwr_ok = sup_s2_ff.vdd_good | sup_s2_ff.vbus_good;

   always_ff @(posedge clk) begin
      if (!resetn) pwr_ok_d_ff <= 1'b0;
      else         pwr_ok_d_ff <= pwr_ok;
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   tcpcpr_state_t      state_ff, nxt_state;
   logic [7:0]         cnt_ff;
   logic               rise;
   logic               soft_reset_bit_ff;

   assign rise = pwr_ok & ~pwr_ok_d_ff;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF:   if (rise) nxt_state = ST_LOAD;
         ST_LOAD:  if (cnt_ff == 8'(HOLD - 1)) nxt_state = ST_FUSE;
         ST_FUSE:  if (cnt_ff == 8'(FUSES - 1)) nxt_state = ST_STRAP;
         ST_STRAP: nxt_state = ST_RUN;
         ST_RUN:   if (soft_reset_bit_ff) nxt_state = ST_LOAD;
         default:  nxt_state = ST_OFF;
      endcase
      if (!pwr_ok) nxt_state = ST_OFF;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_ff <= ST_OFF;
         cnt_ff   <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= (nxt_state != state_ff) ? 8'h00 : cnt_ff + 8'h01;
      end
   end

   // Held through the whole reset so a second write cannot retrigger midway
   always_ff @(posedge clk) begin
      if (!resetn)                                      soft_reset_bit_ff <= 1'b0;
      else if (state_ff == ST_STRAP)                    soft_reset_bit_ff <= 1'b0;
      else if (state_ff == ST_RUN && soft_reset_bit_wr) soft_reset_bit_ff <= 1'b1;
   end

   assign soft_reset_bit = soft_reset_bit_ff;
   assign regs_default   = (state_ff == ST_LOAD);
   assign ready          = (state_ff == ST_RUN);
   assign fuse_rd_idx    = cnt_ff[$clog2(FUSES)-1:0];

   // ==========================================================
   // Fuse trim capture
   // ==========================================================
   generate
      for (genvar g = 0; g < FUSES; g++) begin : g_fuse
         always_ff @(posedge clk) begin
            if (!resetn)
               fuse_trim[g] <= 8'h00;
            else if (state_ff == ST_FUSE && cnt_ff == 8'(g))
               fuse_trim[g] <= fuse_rd_data;
         end
      end
   endgenerate

   // ==========================================================
   // CC terminations and address strap
   // ==========================================================
   logic       strap_ff, pair_ff;
   logic [7:0] role_ff;

   always_ff @(posedge clk) begin
      if (!resetn || state_ff == ST_OFF)    role_ff <= ROLE_CTRL_OPEN;
      else if (state_ff == ST_LOAD)         role_ff <= ROLE_CTRL_RST;
      else if (state_ff == ST_RUN && role_wr) role_ff <= role_wr_data;
   end

   assign cc_role_control = role_ff;
   assign cc_terms_enable = (state_ff != ST_OFF) & sup_s2_ff.vdd_good;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         strap_ff <= 1'b0;
         pair_ff  <= 1'b0;
      end else if (state_ff == ST_STRAP) begin
         strap_ff <= strap_s2_ff;
         pair_ff  <= pair_s2_ff;
      end
   end

   assign slave_addr = {ADDR_UPPER, pair_ff, strap_ff, 1'b0};

   // Pin is an input until the strap is captured
   always_ff @(posedge clk) begin
      if (!resetn) begin
         orient_addr_strap_pin_oe  <= 1'b0;
         orient_addr_strap_pin_out <= 1'b0;
      end else begin
         orient_addr_strap_pin_oe  <= (state_ff == ST_RUN);
         orient_addr_strap_pin_out <= (state_ff == ST_RUN) & ctrl_in.strap_out_val;
      end
   end

   // ==========================================================
   // Interrupt events
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!resetn) begin
         port_pwr_event <= 1'b0;
         init_event     <= 1'b0;
      end else if (state_ff == ST_STRAP) begin
         port_pwr_event <= 1'b1;
         init_event     <= 1'b1;
      end else begin
         if (clr_wr.port_pwr_clr) port_pwr_event <= 1'b0;
         if (clr_wr.init_clr)     init_event     <= 1'b0;
      end
   end

   // Open drain: output always low, only the enable moves
   assign int_n_out = 1'b0;
   always_ff @(posedge clk) begin
      if (!resetn) int_n_oe <= 1'b0;
      else         int_n_oe <= (port_pwr_event | init_event) & (state_ff == ST_RUN);
   end

   // ==========================================================
   // Source switch outputs
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!resetn || state_ff != ST_RUN) begin
         hv_source_switch_out   <= 1'b0;
         vbus_source_switch_out <= 1'b0;
      end else begin
         hv_source_switch_out   <= ctrl_in.hv_source_on;
         vbus_source_switch_out <= ctrl_in.vbus_source_on;
      end
   end

endmodule : tcpcpr_seq

// [verilog/tcpcpr_pkg.sv]
package tcpcpr_pkg;

   // ==========================================================
   // Reset values and timing
   // ==========================================================
   localparam logic [7:0] ROLE_CTRL_RST   = 8'h05;
   localparam logic [7:0] ROLE_CTRL_OPEN  = 8'h0f;
   localparam logic [4:0] ADDR_UPPER      = 5'h14;
   localparam int         ADDR_PAIR_BIT   = 2;
   localparam int         ADDR_STRAP_BIT  = 1;
   localparam int         FUSE_WORDS      = 4;
   localparam int         POR_HOLD_CYC    = 8;

   // ==========================================================
   // Sequencer states, Gray coded along the power-up path
   // ==========================================================
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_LOAD  = 3'b001,
      ST_FUSE  = 3'b011,
      ST_STRAP = 3'b010,
      ST_RUN   = 3'b110
   } tcpcpr_state_t;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic       vdd_good;
      logic       vbus_good;
   } tcpcpr_supply_t;

   typedef struct packed {
      logic       hv_source_on;
      logic       vbus_source_on;
      logic       strap_out_val;
   } tcpcpr_ctrl_t;

   typedef struct packed {
      logic       port_pwr_clr;
      logic       init_clr;
   } tcpcpr_clr_t;

endpackage : tcpcpr_pkg

// [dv/tcpcpr_seq_monitor.sv]
module tcpcpr_seq_monitor
   import tcpcpr_pkg::*;
#(
   parameter int FUSES = FUSE_WORDS,
   parameter int HOLD  = POR_HOLD_CYC
) (
   input wire logic                    clk,
   input wire logic                    resetn,
   input wire logic                    soft_reset_bit_wr,
   input wire tcpcpr_pkg::tcpcpr_clr_t clr_wr,
   input wire logic                    regs_default,
   input wire logic                    soft_reset_bit,
   input wire logic [7:0]              cc_role_control,
   input wire logic [7:0]              slave_addr,
   input wire logic                    orient_addr_strap_pin_oe,
   input wire logic                    int_n_out,
   input wire logic                    int_n_oe,
   input wire logic                    port_pwr_event,
   input wire logic                    init_event,
   input wire logic                    hv_source_switch_out,
   input wire logic                    vbus_source_switch_out,
   input wire logic                    ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic rd_ff;
   int   len_ff;
   // ==========================================================
   // Length of the last default-load phase
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_ff  <= 1'b0;
         len_ff <= 0;
      end else begin
         rd_ff <= regs_default;
         if (regs_default) len_ff <= rd_ff ? len_ff + 1 : 1;
      end
   end
   sequence s_run_entry; $rose(ready); endsequence
   sequence s_soft_taken; ready && soft_reset_bit_wr; endsequence
   property p_load_len;
      s_run_entry |-> len_ff == HOLD && $past(regs_default, FUSES + 2)
                      && !$past(regs_default, FUSES + 1);
   endproperty
   a_load_len: assert property (p_load_len) else $error("load/fuse phase length off");
   property p_entry;
      s_run_entry |-> cc_role_control == ROLE_CTRL_RST && port_pwr_event && init_event
                      && !soft_reset_bit;
   endproperty
   a_entry: assert property (p_entry) else $error("bad state at run entry");
   property p_int_rise; s_run_entry |=> int_n_oe; endproperty
   a_int_rise: assert property (p_int_rise) else $error("interrupt not raised");
   property p_int_pin;
      ready && $past(ready) |-> !int_n_out && int_n_oe == $past(port_pwr_event || init_event);
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("interrupt pin wrong");
   property p_clear;
      ready && !soft_reset_bit_wr |=> init_event == ($past(init_event) && !$past(clr_wr.init_clr))
         && port_pwr_event == ($past(port_pwr_event) && !$past(clr_wr.port_pwr_clr));
   endproperty
   a_clear: assert property (p_clear) else $error("event clear wrong");
   // Run is left two cycles after the bit is taken
   property p_soft;
      s_soft_taken |=> soft_reset_bit ##1 (soft_reset_bit && !ready);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset not taken");
   property p_addr; ready |-> slave_addr[7:3] == ADDR_UPPER && !slave_addr[0]; endproperty
   a_addr: assert property (p_addr) else $error("address fixed bits wrong");
   property p_addr_hold; ready && $past(ready) |-> $stable(slave_addr); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_idle_off;
      !ready && !$past(ready) |-> !orient_addr_strap_pin_oe && !hv_source_switch_out
                                   && !vbus_source_switch_out;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("outputs on while idle");
endmodule : tcpcpr_seq_monitor
bind tcpcpr_seq tcpcpr_seq_monitor #(.FUSES(FUSES), .HOLD(HOLD)) mon_u (.clk, .resetn,
   .soft_reset_bit_wr, .clr_wr, .regs_default, .soft_reset_bit, .cc_role_control, .slave_addr,
   .orient_addr_strap_pin_oe, .int_n_out, .int_n_oe, .port_pwr_event, .init_event,
   .hv_source_switch_out, .vbus_source_switch_out, .ready);

// [dv/tcpcpr_host.sv]
module tcpcpr_host
   import tcpcpr_pkg::*;
(
   input  wire logic                clk,
   input  wire logic [1:0]          fuse_rd_idx,
   output logic                     soft_reset_bit_wr,
   output tcpcpr_pkg::tcpcpr_clr_t  clr_wr,
   output logic                     role_wr,
   output logic [7:0]               role_wr_data,
   output logic [7:0]               fuse_rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // Fuse word i reads back as a0 plus i
   assign fuse_rd_data = {6'h28, fuse_rd_idx};
   initial begin
      soft_reset_bit_wr = 1'b0;
      clr_wr = '0;
      role_wr = 1'b0;
      role_wr_data = 8'h00;
   end
   // One register write cycle; data inverted once released
   task pulse(input logic sw, input tcpcpr_clr_t c, input logic rw, input logic [7:0] d);
      @(posedge clk);
      #1;
      soft_reset_bit_wr = sw;
      clr_wr = c;
      role_wr = rw;
      role_wr_data = d;
      @(posedge clk);
      #1;
      soft_reset_bit_wr = 1'b0;
      clr_wr = '0;
      role_wr = 1'b0;
      role_wr_data = ~d;
   endtask : pulse
endmodule : tcpcpr_host

// [dv/tcpcpr_seq_tb.sv]
module tcpcpr_seq_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tcpcpr_pkg::*;
   logic clk = 0, resetn = 0, strap_drv = 0, bus_pair2 = 0;
   tcpcpr_supply_t supply_pin = '0;
   tcpcpr_ctrl_t ctrl_in = '0;
   tcpcpr_clr_t clr_wr;
   logic sw_wr, role_wr, rd_def, sr_bit, terms, s_out, s_oe;
   logic int_o, int_oe, ev_p, ev_i, hv, vb, ready;
   logic [7:0] role_d, fuse_d, role, addr, trim [4];
   logic [1:0] idx;
   wire logic strap_lvl = s_oe ? s_out : strap_drv;
   int errors = 0, total_checks = 0;
   always #25 clk = ~clk;
   tcpcpr_seq #(.FUSES(4), .HOLD(3)) dut_u (.clk, .resetn, .supply_pin, .strap_pin_in(strap_lvl),
      .bus_pair2, .soft_reset_bit_wr(sw_wr), .clr_wr, .ctrl_in, .role_wr_data(role_d), .role_wr,
      .fuse_rd_data(fuse_d), .fuse_rd_idx(idx), .fuse_trim(trim), .regs_default(rd_def),
      .soft_reset_bit(sr_bit), .cc_role_control(role), .cc_terms_enable(terms), .slave_addr(addr),
      .orient_addr_strap_pin_out(s_out), .orient_addr_strap_pin_oe(s_oe), .int_n_out(int_o),
      .int_n_oe(int_oe), .port_pwr_event(ev_p), .init_event(ev_i), .hv_source_switch_out(hv),
      .vbus_source_switch_out(vb), .ready);
   tcpcpr_host host_u (.clk, .fuse_rd_idx(idx),
      .soft_reset_bit_wr(sw_wr), .clr_wr, .role_wr, .role_wr_data(role_d), .fuse_rd_data(fuse_d));
   task close_out;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task wait_ready;
      for (int i = 0; i < 40 && ready !== 1'b1; i++) step(1);
      chk(ready, 8'h01);
   endtask : wait_ready
   task t_power(input logic vdd, input logic vbs, input logic st, input logic pr);
      chk(role, ROLE_CTRL_OPEN);
      chk(terms, 8'h00);
      strap_drv = st;
      bus_pair2 = pr;
      supply_pin = {vdd, vbs};
      wait_ready;
      chk(role, ROLE_CTRL_RST);
      chk(terms, {7'h0, vdd});
      chk(addr, {ADDR_UPPER, pr, st, 1'b0});
      for (int i = 0; i < 4; i++) chk(trim[i], 8'ha0 | 8'(i));
      step(1);
      chk({int_o, int_oe, ev_p, ev_i, s_oe}, 8'h0f);
   endtask : t_power
   task t_clear;
      host_u.pulse(1'b0, 2'b00, 1'b0, 8'h00);
      step(1);
      chk({int_oe, ev_p, ev_i}, 8'h07);
      host_u.pulse(1'b0, 2'b10, 1'b0, 8'h00);
      step(1);
      chk({int_oe, ev_p, ev_i}, 8'h05);
      host_u.pulse(1'b0, 2'b01, 1'b0, 8'h00);
      step(1);
      chk({int_oe, ev_p, ev_i}, 8'h00);
   endtask : t_clear
   task t_outputs;
      ctrl_in = 3'b101;
      step(2);
      chk({hv, vb, s_out, strap_lvl}, 8'h0b);
      ctrl_in = 3'b010;
      step(2);
      chk({hv, vb, s_out, strap_lvl}, 8'h04);
   endtask : t_outputs
   task t_soft;
      host_u.pulse(1'b0, 2'b11, 1'b1, 8'h22);
      chk(role, 8'h22);
      step(1);
      chk({int_oe, ev_p, ev_i}, 8'h00);
      strap_drv = 1'b1;
      host_u.pulse(1'b1, 2'b00, 1'b0, 8'h00);
      chk({sr_bit, ready}, 8'h03);
      step(1);
      chk({sr_bit, ready, rd_def}, 8'h05);
      wait_ready;
      chk({7'h00, sr_bit}, 8'h00);
      chk(role, ROLE_CTRL_RST);
      chk(addr, {ADDR_UPPER, 3'b110});
      step(1);
      chk({int_oe, ev_p, ev_i}, 8'h07);
   endtask : t_soft
   initial begin
      #200000;
      errors++;
      close_out;
   end
   initial begin
      step(4);
      resetn = 1'b1;
      for (int i = 0; i < 4; i++) begin
         t_power(i != 1, i != 0, i[0], i[1]);
         t_clear;
         supply_pin = '0;
         step(4);
      end
      t_power(1'b1, 1'b1, 1'b0, 1'b1);
      t_outputs;
      t_soft;
      close_out;
   end
endmodule : tcpcpr_seq_tb
